// ---- hw/splc_pkg.sv ----
// constants shared by the serial level controller ends
// assumes one system clock at 40 MHz on both ends
package splc_pkg;
   // ==========================================================
   // frame layout
   localparam int          FRAME_BITS    = 16;
   localparam int          RW_BIT        = 15;
   localparam int          ADDR_MSB      = 14;
   localparam int          ADDR_LSB      = 8;
   localparam int          DATA_MSB      = 7;
   localparam int          NUM_PORTS     = 10;
   // ==========================================================
   // device register addresses
   localparam logic [6:0]  ADDR_PORT9    = 7'h09;
   localparam logic [6:0]  ADDR_GRP_ALL  = 7'h0A;
   localparam logic [6:0]  ADDR_GRP_LOW  = 7'h0B;
   localparam logic [6:0]  ADDR_GRP_MID  = 7'h0C;
   localparam logic [6:0]  ADDR_GRP_TOP  = 7'h0D;
   localparam logic [7:0]  LEVEL_RESET   = 8'hFF;
   localparam logic [7:0]  LEVEL_LOW     = 8'h00;
   localparam logic [7:0]  LEVEL_HIGH    = 8'h01;
   // ==========================================================
   // timing
   localparam int          CLK_PERIOD_NS = 25;
   localparam int          CHAIN_MIN_SCLK_NS = 100;
   // shortest legal half period of the link clock, rounded up
   localparam int          CHAIN_MIN_HALF_CYC =
      (CHAIN_MIN_SCLK_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // sync delay on both ends needs this many cycles per half period
   localparam int          HALF_MIN_CYC  = 8;
   localparam logic [7:0]  HALF_RESET    = 8'h08;
   // ==========================================================
   // controller registers, byte addresses
   localparam logic [7:0]  OFS_TXDATA    = 8'h00;
   localparam logic [7:0]  OFS_CTRL      = 8'h04;
   localparam logic [7:0]  OFS_HALF      = 8'h08;
   localparam logic [7:0]  OFS_STATUS    = 8'h0C;
   localparam logic [7:0]  OFS_RXDATA    = 8'h10;
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h0,
      ST_START = 3'h1,
      ST_HIGH  = 3'h3,
      ST_LOW   = 3'h2,
      ST_STOP  = 3'h7,
      ST_GAP   = 3'h5
   } splc_state_t;
endpackage : splc_pkg

// ---- hw/splc_if.sv ----
// four wire serial link between controller and level device
// assumes the bench joins both modports; all wires are push-pull
`timescale 1ns/100ps
interface splc_if;
   logic sclk;
   logic cs_n;
   logic din;
   logic dout;

   modport dev (
      input  sclk,
      input  cs_n,
      input  din,
      output dout
   );
   modport host (
      output sclk,
      output cs_n,
      output din,
      input  dout
   );
endinterface : splc_if

// ---- hw/splc_sync.sv ----
// two flop synchroniser for levels from outside the clock domain
// assumes aclk runs much faster than any input toggles
`timescale 1ns/100ps
module splc_sync #(
   parameter int W = 1
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= '0;
         sync_out <= '0;
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule : splc_sync

// ---- hw/splc_dev.sv ----
// serial port level device: ten open-drain level registers
// assumes the link pins come from another domain; samples them on aclk
// Overview of operation
// - ten level registers at addresses 0x00-0x09
// - 0x00 drives low, 0x01 releases pin
// - 0x0A writes all ports, reads port zero
// - 0x0B writes ports 0-3, reads port zero
// - 0x0C writes ports 4-7, reads port four
// - 0x0D writes ports 8-9, reads port eight
// - sixteen bit frame: command byte, data byte
// - sample input on rising serial clock
// - ignore clock and data while select high
// - host: clock low before select falls
// - host: write frame msb first, top bit low
// - host: raise select, then leave clock low
// - keep last sixteen bits, load on select rise
// - read: top bit high, address, dummy data
// - read loads addressed data into low byte
// - read data is second byte of next frame
// - output is input delayed 15.5 clocks
// - host: sixteen clocks per chained device
// - host: chained clock at most 10 MHz
`timescale 1ns/100ps
module splc_dev
   import splc_pkg::*;
(
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   splc_if.dev                       link,
   output logic [splc_pkg::NUM_PORTS-1:0] io_port_pins_out,
   output logic [splc_pkg::NUM_PORTS-1:0] io_port_pins_oe,
   output logic [7:0]                level_mon [splc_pkg::NUM_PORTS]
);
   import splc_pkg::*;

   // ==========================================================
   // decode helpers
   function automatic logic [NUM_PORTS-1:0] write_mask(input logic [6:0] a);
      logic [NUM_PORTS-1:0] m;
      m = '0;
      if (a <= ADDR_PORT9) begin
         m[a[3:0]] = 1'b1;
      end else if (a == ADDR_GRP_ALL) begin
         m = '1;
      end else if (a == ADDR_GRP_LOW) begin
         m = 10'h00F;
      end else if (a == ADDR_GRP_MID) begin
         m = 10'h0F0;
      end else if (a == ADDR_GRP_TOP) begin
         m = 10'h300;
      end
      return m;
   endfunction : write_mask

   // ==========================================================
   // input sampling
   logic        sclk_s;
   logic        cs_n_s;
   logic        sel_s;
   logic        din_s;
   logic        sclk_d_reg;
   logic        cs_n_d_reg;
   logic [15:0] shift_reg;
   logic [15:0] shift_next;
   logic        dout_reg;
   logic [7:0]  level_reg [NUM_PORTS];

   splc_sync #(.W(3)) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in ({link.sclk, ~link.cs_n, link.din}),
      .sync_out ({sclk_s, sel_s, din_s})
   );

   // select synced active high: its reset value is the idle level, no false rise
   assign cs_n_s = !sel_s;

   wire        sel      = !cs_n_s;
   wire        sclk_up  = sel && sclk_s && !sclk_d_reg;
   wire        sclk_dn  = sel && !sclk_s && sclk_d_reg;
   wire        cs_fall  = !cs_n_s && cs_n_d_reg;
   wire        cs_rise  = cs_n_s && !cs_n_d_reg;
   wire        is_read  = shift_reg[RW_BIT];
   wire [6:0]  cmd_addr = shift_reg[ADDR_MSB:ADDR_LSB];
   wire [NUM_PORTS-1:0] wmask = write_mask(cmd_addr);

   // read source; groups answer with their first port
   wire [3:0]  rd_idx   = (cmd_addr == ADDR_GRP_ALL) ? 4'h0 :
                          (cmd_addr == ADDR_GRP_LOW) ? 4'h0 :
                          (cmd_addr == ADDR_GRP_MID) ? 4'h4 :
                          (cmd_addr == ADDR_GRP_TOP) ? 4'h8 :
                          cmd_addr[3:0];
   wire        rd_hit   = (cmd_addr <= ADDR_GRP_TOP);
   wire [7:0]  rd_data  = rd_hit ? level_reg[rd_idx] : 8'h00;

   // old bits are cleared only by reset, not when select falls, so short frames mix with earlier ones
   always_comb begin
      shift_next = shift_reg;
      if (sclk_up) begin
         shift_next = {shift_reg[14:0], din_s};
      end else if (cs_rise && is_read) begin
         shift_next = {shift_reg[15:8], rd_data};
      end
   end

   // ==========================================================
   // link state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sclk_d_reg <= 1'b0;
         cs_n_d_reg <= 1'b1;
         shift_reg  <= 16'h0000;
         dout_reg   <= 1'b0;
      end else begin
         sclk_d_reg <= sclk_s;
         cs_n_d_reg <= cs_n_s;
         shift_reg  <= shift_next;
         if (sclk_dn || cs_fall) begin
            dout_reg <= shift_reg[15];
         end
      end
   end

   assign link.dout = dout_reg;

   // ==========================================================
   // level registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_PORTS; i++) begin
            level_reg[i] <= LEVEL_RESET;
         end
      end else if (cs_rise && !is_read) begin
         for (int i = 0; i < NUM_PORTS; i++) begin
            if (wmask[i]) begin
               level_reg[i] <= shift_reg[DATA_MSB:0];
            end
         end
      end
   end

   // only an all-zero level pulls the pin; anything else releases it
   always_comb begin
      for (int i = 0; i < NUM_PORTS; i++) begin
         io_port_pins_out[i] = 1'b0;
         io_port_pins_oe[i]  = (level_reg[i] == LEVEL_LOW);
         level_mon[i]        = level_reg[i];
      end
   end
endmodule : splc_dev

// ---- hw/splc_host.sv ----
// serial link controller with an AXI4-Lite register slave
// assumes software polls status; link clock is divided from aclk
`timescale 1ns/100ps
module splc_host
   import splc_pkg::*;
#(
   parameter int HALF_MIN = splc_pkg::HALF_MIN_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   splc_if.host             link,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   import splc_pkg::*;

   if (HALF_MIN < HALF_MIN_CYC || HALF_MIN < CHAIN_MIN_HALF_CYC || HALF_MIN > 255) begin
      $error("HALF_MIN out of range");
   end

   // ==========================================================
   // register bus
   logic        aw_reg, w_reg;
   logic [7:0]  awaddr_reg;
   logic [31:0] wdata_reg;
   logic [31:0] tx_reg, rx_reg;
   logic        two_reg;
   logic [7:0]  half_reg;
   splc_state_t st_reg;
   logic [7:0]  cnt_reg;
   logic [5:0]  bits_reg;
   logic        sclk_reg, cs_n_reg, din_reg;
   logic        dout_s;

   assign s_axi_awready = !aw_reg;
   assign s_axi_wready  = !w_reg;
   assign s_axi_arready = !s_axi_rvalid;

   wire        busy     = (st_reg != ST_IDLE);
   wire        do_wr    = aw_reg && w_reg && !s_axi_bvalid;
   wire        wr_tx    = do_wr && (awaddr_reg == OFS_TXDATA);
   wire        wr_ctrl  = do_wr && (awaddr_reg == OFS_CTRL);
   wire        wr_half  = do_wr && (awaddr_reg == OFS_HALF);
   wire        wr_ok    = wr_tx || wr_ctrl || wr_half;
   wire        start    = wr_tx && !busy;
   wire [7:0]  half_w   = (wdata_reg[7:0] < 8'(HALF_MIN)) ? 8'(HALF_MIN) : wdata_reg[7:0];
   wire        rd_take  = s_axi_arvalid && !s_axi_rvalid;
   wire        rd_ok    = (s_axi_araddr <= OFS_RXDATA) && (s_axi_araddr[1:0] == 2'h0);
   wire [31:0] rd_mux   = (s_axi_araddr == OFS_TXDATA) ? tx_reg :
                          (s_axi_araddr == OFS_CTRL)   ? {31'h0, two_reg} :
                          (s_axi_araddr == OFS_HALF)   ? {24'h0, half_reg} :
                          (s_axi_araddr == OFS_STATUS) ? {31'h0, busy} :
                          rx_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_reg       <= 1'b0;
         w_reg        <= 1'b0;
         awaddr_reg   <= 8'h00;
         wdata_reg    <= 32'h0000_0000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= RESP_OKAY;
         s_axi_rdata  <= 32'h0000_0000;
         two_reg      <= 1'b0;
         half_reg     <= HALF_RESET;
      end else begin
         if (s_axi_awvalid && !aw_reg) begin
            aw_reg     <= 1'b1;
            awaddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_reg) begin
            w_reg     <= 1'b1;
            wdata_reg <= s_axi_wdata;
         end
         if (do_wr) begin
            aw_reg       <= 1'b0;
            w_reg        <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_ctrl && !busy) begin
            two_reg <= wdata_reg[0];
         end
         if (wr_half && !busy) begin
            half_reg <= half_w;
         end
         if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            s_axi_rdata  <= rd_ok ? rd_mux : 32'h0000_0000;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================================
   // link engine
   splc_sync #(.W(1)) u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (link.dout),
      .sync_out (dout_s)
   );

   wire       half_done = (cnt_reg == half_reg - 8'h01);
   wire [5:0] frame_len = two_reg ? 6'(2 * FRAME_BITS) : 6'(FRAME_BITS);
   wire [7:0] cnt_next  = half_done ? 8'h00 : cnt_reg + 8'h01;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg   <= ST_IDLE;
         cnt_reg  <= 8'h00;
         bits_reg <= 6'h00;
         sclk_reg <= 1'b0;
         cs_n_reg <= 1'b1;
         din_reg  <= 1'b0;
         tx_reg   <= 32'h0000_0000;
         rx_reg   <= 32'h0000_0000;
      end else begin
         cnt_reg <= (st_reg == ST_IDLE) ? 8'h00 : cnt_next;
         case (st_reg)
            ST_IDLE: begin
               if (start) begin
                  tx_reg   <= wdata_reg;
                  bits_reg <= frame_len;
                  cs_n_reg <= 1'b0;
                  din_reg  <= two_reg ? wdata_reg[31] : wdata_reg[15];
                  st_reg   <= ST_START;
               end
            end
            ST_START, ST_LOW: begin
               if (half_done) begin
                  sclk_reg <= 1'b1;
                  rx_reg   <= {rx_reg[30:0], dout_s};
                  st_reg   <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (half_done) begin
                  sclk_reg <= 1'b0;
                  bits_reg <= bits_reg - 6'h01;
                  tx_reg   <= {tx_reg[30:0], 1'b0};
                  din_reg  <= two_reg ? tx_reg[30] : tx_reg[14];
                  st_reg   <= (bits_reg == 6'h01) ? ST_STOP : ST_LOW;
               end
            end
            ST_STOP: begin
               if (half_done) begin
                  cs_n_reg <= 1'b1;
                  st_reg   <= ST_GAP;
               end
            end
            ST_GAP: begin
               if (half_done) begin
                  st_reg <= ST_IDLE;
               end
            end
            default: begin
               st_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // divided clock is at most 2.5 MHz, well under the chain limit
   assign link.sclk = sclk_reg;
   assign link.cs_n = cs_n_reg;
   assign link.din  = din_reg;
endmodule : splc_host

// ---- dv/splc_link_chk.sv ----
// checker on the serial link joining controller and level device
// assumes plain inputs from the interface, sync active low reset
`timescale 1ns/100ps
module splc_link_chk (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   input wire logic dout
);
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ==========================================================
   // rising edges counted within a frame
   logic       sclk_reg;
   logic [5:0] rise_reg;
   logic [5:0] rise_next;
   assign rise_next = (cs_n) ? 6'h00 : rise_reg + {5'h00, sclk & ~sclk_reg};
   always_ff @(posedge aclk) begin
      sclk_reg <= sclk;
      rise_reg <= (!aresetn) ? 6'h00 : rise_next;
   end
   // ==========================================================
   // properties
   sequence s_hi8;
      sclk [*8];
   endsequence
   sequence s_lo8;
      !sclk [*8];
   endsequence
   AST_SEL_CLK_LOW: assert property ($fell(cs_n) |-> s_lo8)
      else $error("clock not low at select");
   AST_IDLE_CLK_LOW: assert property (cs_n |-> !sclk)
      else $error("clock moves while deselected");
   AST_DIN_HELD: assert property ((!cs_n && sclk) |-> $stable(din))
      else $error("data changed while clock high");
   AST_HIGH_SPAN: assert property ($rose(sclk) |-> s_hi8)
      else $error("clock high phase too short");
   AST_LOW_SPAN: assert property ($fell(sclk) |-> s_lo8)
      else $error("clock low phase too short");
   AST_FRAME_LEN: assert property ($rose(cs_n) |-> (rise_reg == 6'h10 || rise_reg == 6'h20))
      else $error("frame clock count wrong");
   AST_DOUT_ON_LOW: assert property ($changed(dout) |-> !sclk)
      else $error("output changed while clock high");
   AST_DOUT_IDLE: assert property ((cs_n && $past(cs_n)) |-> $stable(dout))
      else $error("output moved while deselected");
endmodule : splc_link_chk

// ---- dv/testbench.sv ----
// bench joining controller and level device across the serial link
// assumes the controller map of the package; software side is AXI4-Lite
`timescale 1ns/100ps
module testbench;
   import splc_pkg::*;
   logic        aclk, aresetn;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready;
   logic [1:0]  bresp, rresp;
   logic [9:0]  io_port_pins_out, io_port_pins_oe;
   logic [7:0]  level_mon [NUM_PORTS];
   logic [7:0]  exp_lvl [NUM_PORTS];
   logic [6:0]  g_addr [4] = '{ADDR_GRP_ALL, ADDR_GRP_LOW, ADDR_GRP_MID, ADDR_GRP_TOP};
   int          g_lo [4] = '{0, 0, 4, 8};
   int          g_hi [4] = '{9, 3, 7, 9};
   int          fail_count, check_count;
   splc_if link();
   splc_host #(.HALF_MIN(HALF_MIN_CYC)) i_splc_host (.aclk(aclk), .aresetn(aresetn),
      .link(link), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   splc_dev i_splc_dev (.aclk(aclk), .aresetn(aresetn), .link(link),
      .io_port_pins_out(io_port_pins_out), .io_port_pins_oe(io_port_pins_oe),
      .level_mon(level_mon));
   splc_link_chk i_splc_link_chk (.aclk(aclk), .aresetn(aresetn), .sclk(link.sclk),
      .cs_n(link.cs_n), .din(link.din), .dout(link.dout));
   // ==========================================================
   // bus and compare tasks
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask : axi_rd
   task automatic chk_ports();
      for (int i = 0; i < NUM_PORTS; i++) begin
         chk("level", {24'h0, exp_lvl[i]}, {24'h0, level_mon[i]});
         chk("oe", {31'h0, exp_lvl[i] == LEVEL_LOW}, {31'h0, io_port_pins_oe[i]});
      end
      chk("pins_out", 32'h0, {22'h0, io_port_pins_out});
   endtask : chk_ports
   // levels must hold while the frame is still shifting
   task automatic send(input logic [31:0] d);
      logic [31:0] s;
      logic [1:0]  r;
      axi_wr(OFS_TXDATA, d, r);
      do begin
         if (link.cs_n === 1'b0) chk_ports();
         axi_rd(OFS_STATUS, s, r);
      end while (s[0] === 1'b1);
   endtask : send
   task automatic rd_port(input logic [6:0] a, input logic [7:0] exp);
      logic [31:0] s;
      logic [1:0]  r;
      send({16'h0000, 1'b1, a, 8'hA5});
      send({16'h0000, 1'b1, ADDR_PORT9, 8'h00});
      axi_rd(OFS_RXDATA, s, r);
      chk("read", {24'h0, exp}, {24'h0, s[7:0]});
      chk_ports();
   endtask : rd_port
   // ==========================================================
   // scenarios
   task automatic t_reset();
      logic [31:0] s;
      logic [1:0]  r;
      for (int i = 0; i < NUM_PORTS; i++) exp_lvl[i] = LEVEL_RESET;
      chk_ports();
      axi_wr(OFS_HALF, 32'h00000002, r);
      chk("half_resp", {30'h0, RESP_OKAY}, {30'h0, r});
      axi_rd(OFS_HALF, s, r);
      chk("half", {24'h0, 8'(HALF_MIN_CYC)}, s);
      axi_rd(8'h14, s, r);
      chk("rd_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      axi_wr(8'h14, 32'h00000001, r);
      chk("wr_resp", {30'h0, RESP_SLVERR}, {30'h0, r});
      $display("test reset done");
   endtask : t_reset
   task automatic t_ports();
      logic [7:0] v;
      for (int i = 0; i < NUM_PORTS; i++) begin
         v = (i % 2) ? LEVEL_HIGH : LEVEL_LOW;
         send({16'h0000, 1'b0, 7'(i), v});
         exp_lvl[i] = v;
         chk_ports();
      end
      rd_port(7'h04, exp_lvl[4]);
      rd_port(7'h05, exp_lvl[5]);
      $display("test ports done");
   endtask : t_ports
   task automatic t_groups();
      for (int g = 0; g < 4; g++) begin
         send({16'h0000, 1'b0, ADDR_GRP_ALL, LEVEL_LOW});
         for (int i = 0; i < NUM_PORTS; i++) exp_lvl[i] = LEVEL_LOW;
         send({16'h0000, 1'b0, g_addr[g], LEVEL_HIGH});
         for (int i = g_lo[g]; i <= g_hi[g]; i++) exp_lvl[i] = LEVEL_HIGH;
         chk_ports();
         rd_port(g_addr[g], exp_lvl[g_lo[g]]);
      end
      $display("test groups done");
   endtask : t_groups
   // only the last sixteen bits of an overlong frame may act
   task automatic t_chain();
      logic [31:0] s;
      logic [1:0]  r;
      axi_wr(OFS_CTRL, 32'h00000001, r);
      send(32'h03000501);
      exp_lvl[5] = LEVEL_HIGH;
      chk_ports();
      axi_rd(OFS_RXDATA, s, r);
      chk("chain_rx", 32'h00000300, {16'h0, s[15:0]});
      axi_wr(OFS_CTRL, 32'h00000000, r);
      $display("test chain done");
   endtask : t_chain
   task automatic finish_test();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test
   // ==========================================================
   // clock, reset, sequence and watchdog
   initial begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_ports();
      t_groups();
      t_chain();
      finish_test();
   end
   initial begin
      repeat (80000) @(posedge aclk);
      fail_count++;
      $display("FAIL watchdog expected done seen hang");
      finish_test();
   end
endmodule : testbench
